// ==== fcr_cfg_checker.sv ====
/* Concurrent checks on the config register group ports.
   Assumes mclk-domain event pulses and a chip select that idles high. */
`timescale 1ns/1ps
module fcr_cfg_checker
	import fcr_pkg::*;
(
	input wire logic		mclk,
	input wire logic		resetn,
	input wire logic		link_cs_n,
	input wire logic		link_so_oe_n,
	input wire logic		hw_reset_pulse,
	input wire logic		sw_reset_pulse,
	input wire logic		quad_enable_bit,
	input wire logic		prot_fail_event,
	input wire logic		protection_error_flag,
	input wire logic [3:0]	boot_start_delay,
	input wire logic [3:0]	boot_delay_cycles,
	input wire logic		four_byte_addr_mode,
	input wire logic		upper_segment_bit,
	input wire logic		legacy_addr_bit24,
	input wire logic		legacy_addr_from_bank,
	input wire logic		parameter_block_location,
	input wire logic		password_mode_lock,
	input wire logic		persistent_mode_lock
);
	// ----------------------------------------------------------------
	// cycles since a frame end or a reset pulse
	// ----------------------------------------------------------------
	logic		cs_q;
	logic [3:0]	since_end;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cs_q <= 1'b1;
			since_end <= 4'hf;
		end else begin
			cs_q <= link_cs_n;
			if ((link_cs_n && !cs_q) || hw_reset_pulse || sw_reset_pulse)
				since_end <= 4'h0;
			else if (since_end != 4'hf)
				since_end <= since_end + 4'h1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_flag_sticky: assert property ($fell(protection_error_flag) |-> since_end <= 4'ha)
		else $error("error flag fell without clear or reset");
	a_event_sets: assert property (prot_fail_event |-> ##2 protection_error_flag)
		else $error("fail event did not set flag");
	a_reset_clears: assert property ((hw_reset_pulse || sw_reset_pulse) && !prot_fail_event
		|-> ##2 !protection_error_flag) else $error("reset pulse did not clear flag");
	a_delay_pick: assert property ($stable(quad_enable_bit) |-> boot_delay_cycles ==
		(boot_start_delay != 4'h0 ? boot_start_delay :
		(quad_enable_bit ? DELAY_DEFAULT_QUAD : DELAY_DEFAULT_SERIAL)))
		else $error("effective boot delay wrong");
	a_bank_addr: assert property (legacy_addr_from_bank == !four_byte_addr_mode
		&& legacy_addr_bit24 == (upper_segment_bit && !four_byte_addr_mode))
		else $error("legacy address bit wrong");
	a_oe_idle: assert property (link_cs_n && $past(link_cs_n) |-> link_so_oe_n)
		else $error("output enabled outside frame");
	a_lock_legal: assert property (password_mode_lock || persistent_mode_lock)
		else $error("both mode locks zero");
	a_loc_upward: assert property (!$fell(parameter_block_location))
		else $error("parameter location fell");
	c_flag: cover property (protection_error_flag);
	c_wide: cover property (four_byte_addr_mode);
	c_read: cover property (!link_so_oe_n);
	c_quad: cover property (boot_delay_cycles == 4'h6);
endmodule : fcr_cfg_checker

bind fcr_flash_config_regs fcr_cfg_checker chk_u (.mclk, .resetn, .link_cs_n, .link_so_oe_n,
	.hw_reset_pulse, .sw_reset_pulse, .quad_enable_bit, .prot_fail_event, .protection_error_flag,
	.boot_start_delay, .boot_delay_cycles, .four_byte_addr_mode, .upper_segment_bit,
	.legacy_addr_bit24, .legacy_addr_from_bank, .parameter_block_location,
	.password_mode_lock, .persistent_mode_lock);

// ==== fcr_flash_config_regs.sv ====
/*
 * Configuration register group of a serial NOR flash: sticky error flags,
 * boot fetch register, bank/address-mode register and protection mode register.
 * Assumes the link clock stops between frames and that the error events and the
 * reset pulses come from logic on mclk.
 */
// Functional notes
// - one-time lock bits only move toward 0, parameter location toward 1; location clears ignored silently.
// - read-only bits and freeze-locked bits never change on writes; no error.
// - error flags stay set until the clear extended read command.
// - hardware or software reset also clears the error flags.
// - commands still execute while any error flag is set.
// - boot register 32 bits; bits 31..5 boot start address, default zero.
// - bits 4..1 boot delay; zero means 8 cycles, or 6 with quad enable.
// - boot register bit 0 enables automatic boot read, default 0.
// - bank register 8 bits, default 0; bits 6..1 reserved read-only.
// - bank bit 0 picks lower or upper 128Mb segment in 3-byte mode.
// - in 3-byte mode bank bit supplies the address bit above A23.
// - in 4-byte mode bank bit ignored; host sends four address bytes.
// - bank bit 7 selects 3 or 4 address bytes, default 0.
// - bank read 16h/C8h, write 17h/C5h, nonvolatile 18h, B7h enter, 29h exit.
// - protection mode register read 2Bh, programmed 2Fh.
// - protection mode register 16 bits, lock bits 2 and 1, location 15, all 1.
// - protection, program and erase failures set their error flags.
// - lock pair 11 none, 10 persistent, 01 password; 00 aborts with error.
// - parameter location 0 puts small sectors at top, 1 at bottom.
`timescale 1ns/1ps
module fcr_flash_config_regs
	import fcr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        link_sck,
	input  wire logic        link_cs_n,
	input  wire logic        link_si,
	output logic             link_so,
	output logic             link_so_oe_n,
	input  wire logic        hw_reset_pulse,
	input  wire logic        sw_reset_pulse,
	input  wire logic        quad_enable_bit,
	input  wire logic        freeze_lock,
	input  wire logic        prot_fail_event,
	input  wire logic        prog_fail_event,
	input  wire logic        erase_fail_event,
	output logic             protection_error_flag,
	output logic             program_error_flag,
	output logic             erase_error_flag,
	output logic [26:0]      boot_start_addr,
	output logic [3:0]       boot_start_delay,
	output logic [3:0]       boot_delay_cycles,
	output logic             boot_fetch_enable,
	output logic             upper_segment_bit,
	output logic             four_byte_addr_mode,
	output logic             legacy_addr_bit24,
	output logic             legacy_addr_from_bank,
	output logic             parameter_block_location,
	output logic             password_mode_lock,
	output logic             persistent_mode_lock
);

	// ----------------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------------
	logic                   rx_in_frame;
	logic [7:0]             rx_opcode;
	logic [31:0]            rx_data;
	logic [FRAME_CNT_W-1:0] rx_count;
	logic                   cs_high;
	logic                   cs_high_prev;
	logic                   frame_end;
	logic                   cmd_go;
	logic [7:0]             cmd_op;
	logic [31:0]            cmd_data;
	logic [FRAME_CNT_W-1:0] cmd_cnt;
	logic                   do_wr_bank;
	logic                   do_wr_bank_nv;
	logic                   do_enter_wide;
	logic                   do_exit_wide;
	logic                   do_wr_boot;
	logic                   do_pg_mode;
	logic                   do_clear;
	logic                   any_reset;
	logic [7:0]             bank;
	logic [7:0]             bank_nv;
	logic [31:0]            boot;
	logic [15:0]            mode;
	logic [15:0]            next_mode;
	logic                   mode_prog_err;
	logic                   mode_prot_err;
	logic [2:0]             err_flag;
	logic [2:0]             err_set;
	logic [31:0]            rd_word;
	logic [6:0]             rd_bits;
	logic [6:0]             rd_idx;
	logic [4:0]             rd_sel;

	// ----------------------------------------------------------------------
	// link side capture and chip select crossing
	// ----------------------------------------------------------------------
	fcr_link_rx u_rx (
		.link_sck  (link_sck),
		.resetn    (resetn),
		.link_cs_n (link_cs_n),
		.link_si   (link_si),
		.in_frame  (rx_in_frame),
		.opcode    (rx_opcode),
		.data      (rx_data),
		.bit_count (rx_count)
	);

	fcr_sync3 #(
		.INIT (1'b1)
	) u_cs_sync (
		.clk   (mclk),
		.rst_n (resetn),
		.din   (link_cs_n),
		.dout  (cs_high)
	);

	assign frame_end = cs_high & ~cs_high_prev;

	// ----------------------------------------------------------------------
	// frame hand-over: receiver words are frozen once chip select is high
	// ----------------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cs_high_prev <= 1'b1;
			cmd_go       <= 1'b0;
			cmd_op       <= 8'h00;
			cmd_data     <= 32'h0000_0000;
			cmd_cnt      <= '0;
		end else begin
			cs_high_prev <= cs_high;
			cmd_go       <= frame_end;
			if (frame_end) begin
				cmd_op   <= rx_opcode;
				cmd_data <= rx_data;
				cmd_cnt  <= rx_count;
			end
		end
	end

	// ----------------------------------------------------------------------
	// command decode; error flags do not gate anything here
	// ----------------------------------------------------------------------
	always_comb begin
		do_wr_bank    = cmd_go && cmd_cnt == OPCODE_BITS + BANK_BITS &&
			(cmd_op == WRITE_BANK_VOLATILE_CMD_A ||
			 cmd_op == WRITE_BANK_VOLATILE_CMD_B);
		do_wr_bank_nv = cmd_go && cmd_cnt == OPCODE_BITS + BANK_BITS &&
			cmd_op == WRITE_BANK_NONVOLATILE_CMD;
		do_enter_wide = cmd_go && cmd_cnt == OPCODE_BITS &&
			cmd_op == ENTER_WIDE_ADDR_CMD;
		do_exit_wide  = cmd_go && cmd_cnt == OPCODE_BITS &&
			cmd_op == EXIT_WIDE_ADDR_CMD;
		do_wr_boot    = cmd_go && cmd_cnt == OPCODE_BITS + BOOT_BITS &&
			cmd_op == WRITE_BOOT_CMD;
		do_pg_mode    = cmd_go && cmd_cnt == OPCODE_BITS + MODE_BITS &&
			cmd_op == PROGRAM_PROTECTION_MODE_CMD;
		do_clear      = cmd_go && cmd_cnt == OPCODE_BITS &&
			cmd_op == CLEAR_EXTENDED_READ_CMD;
	end

	assign any_reset = hw_reset_pulse | sw_reset_pulse;

	// ----------------------------------------------------------------------
	// protection mode programming
	// ----------------------------------------------------------------------
	always_comb begin
		next_mode     = mode;
		mode_prog_err = 1'b0;
		mode_prot_err = 1'b0;
		if (cmd_data[MODE_PWD_LOCK_POS:MODE_PST_LOCK_POS] == LOCK_ILLEGAL) begin
			mode_prog_err = 1'b1;
		end else begin
			if (cmd_data[MODE_PWD_LOCK_POS:MODE_PST_LOCK_POS] !=
			    mode[MODE_PWD_LOCK_POS:MODE_PST_LOCK_POS]) begin
				if (mode[MODE_PWD_LOCK_POS:MODE_PST_LOCK_POS] != LOCK_NONE) begin
					mode_prog_err = 1'b1;
					mode_prot_err = 1'b1;
				end else begin
					next_mode[MODE_PWD_LOCK_POS:MODE_PST_LOCK_POS] =
						cmd_data[MODE_PWD_LOCK_POS:MODE_PST_LOCK_POS];
				end
			end
			// frozen location keeps its value; clearing attempts drop quietly
			if (!freeze_lock)
				next_mode[MODE_PARAM_LOC_POS] = mode[MODE_PARAM_LOC_POS] |
					cmd_data[MODE_PARAM_LOC_POS];
		end
	end

	// ----------------------------------------------------------------------
	// bank register, volatile and nonvolatile copies
	// ----------------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			bank_nv <= BANK_RESET;
		else if (do_wr_bank_nv)
			bank_nv <= cmd_data[7:0] & BANK_WRITABLE;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bank <= BANK_RESET;
		end else if (any_reset) begin
			bank <= bank_nv;
		end else if (do_wr_bank || do_wr_bank_nv) begin
			bank <= cmd_data[7:0] & BANK_WRITABLE;
		end else if (do_enter_wide) begin
			bank[BANK_FOUR_BYTE_POS] <= 1'b1;
		end else if (do_exit_wide) begin
			bank[BANK_FOUR_BYTE_POS] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// boot fetch register, kept across hardware and software reset
	// ----------------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			boot <= BOOT_RESET;
		else if (do_wr_boot)
			boot <= cmd_data;
	end

	// ----------------------------------------------------------------------
	// protection mode register, reserved bits held at one
	// ----------------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			mode <= MODE_RESET;
		else if (do_pg_mode)
			mode <= next_mode;
	end

	// ----------------------------------------------------------------------
	// sticky error flags: a set in the clearing cycle wins
	// ----------------------------------------------------------------------
	assign err_set[ERR_PROT]  = prot_fail_event | (do_pg_mode & mode_prot_err);
	assign err_set[ERR_PROG]  = prog_fail_event | (do_pg_mode & mode_prog_err);
	assign err_set[ERR_ERASE] = erase_fail_event;

	generate
		for (genvar i = 0; i < 3; i++) begin : g_err
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn)
					err_flag[i] <= 1'b0;
				else if (err_set[i])
					err_flag[i] <= 1'b1;
				else if (do_clear)
					err_flag[i] <= 1'b0;
				else if (any_reset)
					err_flag[i] <= 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			protection_error_flag <= 1'b0;
			program_error_flag    <= 1'b0;
			erase_error_flag      <= 1'b0;
		end else begin
			protection_error_flag <= err_flag[ERR_PROT];
			program_error_flag    <= err_flag[ERR_PROG];
			erase_error_flag      <= err_flag[ERR_ERASE];
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			boot_start_addr   <= 27'h0;
			boot_start_delay  <= 4'h0;
			boot_delay_cycles <= DELAY_DEFAULT_SERIAL;
			boot_fetch_enable <= 1'b0;
		end else begin
			boot_start_addr   <= boot[31:BOOT_ADDR_LSB];
			boot_start_delay  <= boot[BOOT_DELAY_MSB:BOOT_DELAY_LSB];
			if (boot[BOOT_DELAY_MSB:BOOT_DELAY_LSB] != 4'h0)
				boot_delay_cycles <= boot[BOOT_DELAY_MSB:BOOT_DELAY_LSB];
			else if (quad_enable_bit)
				boot_delay_cycles <= DELAY_DEFAULT_QUAD;
			else
				boot_delay_cycles <= DELAY_DEFAULT_SERIAL;
			boot_fetch_enable <= boot[BOOT_ENABLE_POS];
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			upper_segment_bit     <= 1'b0;
			four_byte_addr_mode   <= 1'b0;
			legacy_addr_bit24     <= 1'b0;
			legacy_addr_from_bank <= 1'b1;
		end else begin
			upper_segment_bit     <= bank[BANK_UPPER_SEG_POS];
			four_byte_addr_mode   <= bank[BANK_FOUR_BYTE_POS];
			legacy_addr_from_bank <= ~bank[BANK_FOUR_BYTE_POS];
			// wide mode ignores the bank bit for address bit 24
			legacy_addr_bit24     <= bank[BANK_UPPER_SEG_POS] &
				~bank[BANK_FOUR_BYTE_POS];
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			parameter_block_location <= 1'b1;
			password_mode_lock       <= 1'b1;
			persistent_mode_lock     <= 1'b1;
		end else begin
			parameter_block_location <= mode[MODE_PARAM_LOC_POS];
			password_mode_lock       <= mode[MODE_PWD_LOCK_POS];
			persistent_mode_lock     <= mode[MODE_PST_LOCK_POS];
		end
	end

	// ----------------------------------------------------------------------
	// read path on the link clock
	// register words change only between frames or on a reset pulse,
	// so they are steady while a read frame shifts them out
	// ----------------------------------------------------------------------
	always_comb begin
		rd_bits = fcr_rd_bits(rx_opcode);
		rd_idx  = (rx_count - OPCODE_BITS) & (rd_bits - 7'h01);
		rd_sel  = 5'((rd_bits - 7'h01) - rd_idx);
		if (rx_opcode == READ_PROTECTION_MODE_CMD)
			rd_word = {16'h0000, mode};
		else if (rx_opcode == READ_BOOT_CMD)
			rd_word = boot;
		else
			rd_word = {24'h00_0000, bank};
	end

	always_ff @(negedge link_sck or posedge link_cs_n or negedge resetn) begin
		if (!resetn || link_cs_n) begin
			link_so      <= 1'b0;
			link_so_oe_n <= 1'b1;
		end else if (rx_in_frame && rx_count >= OPCODE_BITS && rd_bits != NO_BITS) begin
			link_so      <= rd_word[rd_sel];
			link_so_oe_n <= 1'b0;
		end
	end

endmodule : fcr_flash_config_regs

// ==== fcr_flash_config_regs_tb_top.sv ====
/* Self-checking bench for the config register group.
   Assumes the host model carries all link traffic and mclk runs at 200 MHz. */
`timescale 1ns/1ps
module fcr_flash_config_regs_tb_top;
	import fcr_pkg::*;
	logic mclk, resetn, quad_enable_bit, freeze_lock;
	logic link_sck, link_cs_n, link_si, link_so, link_so_oe_n, so_w;
	logic protection_error_flag, program_error_flag, erase_error_flag;
	logic [26:0] boot_start_addr;
	logic [3:0] boot_start_delay, boot_delay_cycles;
	logic boot_fetch_enable, upper_segment_bit, four_byte_addr_mode;
	logic legacy_addr_bit24, legacy_addr_from_bank, parameter_block_location;
	logic password_mode_lock, persistent_mode_lock;
	logic [4:0] ev;
	logic [31:0] rd_q;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;
	// released line shows the inverse of its last value, so a late enable shows up
	assign so_w = link_so_oe_n ? ~link_so : link_so;
	fcr_host_model host_u (.link_sck, .link_cs_n, .link_si, .link_so(so_w));
	fcr_flash_config_regs dut_u (.mclk, .resetn, .link_sck, .link_cs_n, .link_si, .link_so,
		.link_so_oe_n, .hw_reset_pulse(ev[4]), .sw_reset_pulse(ev[3]), .quad_enable_bit,
		.freeze_lock, .prot_fail_event(ev[0]), .prog_fail_event(ev[1]),
		.erase_fail_event(ev[2]), .protection_error_flag, .program_error_flag,
		.erase_error_flag, .boot_start_addr, .boot_start_delay, .boot_delay_cycles,
		.boot_fetch_enable, .upper_segment_bit, .four_byte_addr_mode, .legacy_addr_bit24,
		.legacy_addr_from_bank, .parameter_block_location, .password_mode_lock,
		.persistent_mode_lock);
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic cmd(input logic [7:0] op, input int n, input logic [31:0] wd);
		host_u.xfer(op, n, wd, rd_q);
		repeat (10) @(posedge mclk);
	endtask : cmd
	task automatic pulse(input logic [4:0] m);
		@(posedge mclk);
		ev <= m;
		@(posedge mclk);
		ev <= 5'h0;
		repeat (3) @(posedge mclk);
	endtask : pulse
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	initial begin
		resetn = 1'b0;
		ev = 5'h0;
		quad_enable_bit = 1'b0;
		freeze_lock = 1'b0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		repeat (5) @(posedge mclk);
		chk({boot_start_addr, boot_start_delay, boot_fetch_enable}, 32'h0);
		chk(boot_delay_cycles, 4'h8);
		chk({four_byte_addr_mode, upper_segment_bit, legacy_addr_from_bank}, 3'b001);
		cmd(READ_BANK_CMD_A, 8, 0);
		chk(rd_q, 32'h00);
		cmd(READ_PROTECTION_MODE_CMD, 16, 0);
		chk(rd_q, 32'hffff);
		$display("test reset done");
		cmd(WRITE_BANK_VOLATILE_CMD_A, 8, 32'hff);
		cmd(READ_BANK_CMD_B, 8, 0);
		chk(rd_q, 32'h81);
		chk({four_byte_addr_mode, upper_segment_bit, legacy_addr_bit24}, 3'b110);
		cmd(EXIT_WIDE_ADDR_CMD, 0, 0);
		chk({legacy_addr_bit24, legacy_addr_from_bank}, 2'b11);
		cmd(ENTER_WIDE_ADDR_CMD, 0, 0);
		chk(four_byte_addr_mode, 1'b1);
		cmd(WRITE_BANK_NONVOLATILE_CMD, 8, 32'h01);
		cmd(WRITE_BANK_VOLATILE_CMD_B, 8, 32'h00);
		// short frame is dropped
		cmd(WRITE_BANK_VOLATILE_CMD_A, 4, 32'h8);
		chk(upper_segment_bit, 1'b0);
		pulse(5'h10);
		chk(upper_segment_bit, 1'b1);
		$display("test bank done");
		cmd(WRITE_BOOT_CMD, 32, 32'hdeadbe1b);
		chk({boot_start_addr, boot_start_delay, boot_fetch_enable}, 32'hdeadbe1b);
		chk(boot_delay_cycles, 4'hd);
		cmd(WRITE_BOOT_CMD, 32, 32'h20);
		quad_enable_bit <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(boot_delay_cycles, 4'h6);
		cmd(READ_BOOT_CMD, 32, 0);
		chk(rd_q, 32'h20);
		$display("test boot done");
		for (int k = 0; k < 2; k++) begin
			pulse(5'h07);
			cmd(WRITE_BANK_VOLATILE_CMD_A, 8, 32'h80);
			chk(four_byte_addr_mode, 1'b1);
			chk({protection_error_flag, program_error_flag, erase_error_flag}, 3'h7);
			pulse(k == 0 ? 5'h10 : 5'h08);
			chk({protection_error_flag, program_error_flag, erase_error_flag}, 3'h0);
		end
		pulse(5'h07);
		cmd(CLEAR_EXTENDED_READ_CMD, 0, 0);
		chk({protection_error_flag, program_error_flag, erase_error_flag}, 3'h0);
		$display("test flags done");
		freeze_lock <= 1'b1;
		cmd(PROGRAM_PROTECTION_MODE_CMD, 16, 32'h7ff9);
		chk({program_error_flag, password_mode_lock, persistent_mode_lock}, 3'h7);
		cmd(CLEAR_EXTENDED_READ_CMD, 0, 0);
		freeze_lock <= 1'b0;
		cmd(PROGRAM_PROTECTION_MODE_CMD, 16, 32'h7ffd);
		chk({parameter_block_location, password_mode_lock, persistent_mode_lock}, 3'h6);
		cmd(READ_PROTECTION_MODE_CMD, 16, 0);
		chk(rd_q, 32'hfffd);
		cmd(PROGRAM_PROTECTION_MODE_CMD, 16, 32'hfffb);
		chk({protection_error_flag, program_error_flag, persistent_mode_lock}, 3'h6);
		$display("test mode done");
		end_of_test();
	end
endmodule : fcr_flash_config_regs_tb_top

// ==== fcr_host_model.sv ====
/* Host end of the serial link: frames opcode and data, captures read bits.
   Assumes the device samples on rising sck and drives so on falling sck. */
`timescale 1ns/1ps
module fcr_host_model (
	output logic		link_sck,
	output logic		link_cs_n,
	output logic		link_si,
	input wire logic	link_so
);
	initial begin
		link_sck = 1'b0;
		link_cs_n = 1'b1;
		link_si = 1'b0;
	end
	// ----------------------------------------------------------------
	// one mode 0 frame, sck still outside it, 6 ns period
	// ----------------------------------------------------------------
	task automatic xfer(input logic [7:0] op, input int n, input logic [31:0] wd,
		output logic [31:0] rd);
		logic [39:0] sh;
		sh = {op, wd << (32 - n)};
		rd = 32'h0;
		#1.7 link_cs_n = 1'b0;
		for (int i = 0; i < 8 + n; i++) begin
			link_si = sh[39];
			sh = sh << 1;
			#3 link_sck = 1'b1;
			if (i >= 8)
				rd = {rd[30:0], link_so};
			#3 link_sck = 1'b0;
		end
		#3 link_cs_n = 1'b1;
		link_si = ~link_si;
	endtask : xfer
endmodule : fcr_host_model

// ==== fcr_link_rx.sv ====
/*
 * Link-side receiver on the serial clock: captures opcode, data bits and bit count.
 * Assumes mode 0 sampling on the rising edge and chip select high between frames.
 */
`timescale 1ns/1ps
module fcr_link_rx
	import fcr_pkg::*;
(
	input  wire logic                          link_sck,
	input  wire logic                          resetn,
	input  wire logic                          link_cs_n,
	input  wire logic                          link_si,
	output logic                               in_frame,
	output logic [7:0]                         opcode,
	output logic [31:0]                        data,
	output logic [fcr_pkg::FRAME_CNT_W-1:0]    bit_count
);

	logic [FRAME_CNT_W-1:0] pos;

	assign pos = in_frame ? bit_count : '0;

	// ----------------------------------------------------------------------
	// frame marker, cleared by chip select since the clock stops
	// ----------------------------------------------------------------------
	always_ff @(posedge link_sck or posedge link_cs_n) begin
		if (link_cs_n)
			in_frame <= 1'b0;
		else
			in_frame <= 1'b1;
	end

	// ----------------------------------------------------------------------
	// bit counter and shifters, held after the frame for the other domain
	// ----------------------------------------------------------------------
	always_ff @(posedge link_sck or negedge resetn) begin
		if (!resetn) begin
			bit_count <= '0;
			opcode    <= 8'h00;
			data      <= 32'h0000_0000;
		end else begin
			bit_count <= pos + 7'h01;
			if (pos < OPCODE_BITS)
				opcode <= {opcode[6:0], link_si};
			else
				data <= {data[30:0], link_si};
		end
	end

endmodule : fcr_link_rx

// ==== fcr_pkg.sv ====
/*
 * Constants shared by the flash configuration register group: command codes,
 * register widths, field positions, reset values and frame lengths.
 * Assumes a serial link that sends an 8-bit opcode first, most significant bit first.
 */
package fcr_pkg;

	// ----------------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------------
	localparam logic [7:0] READ_BANK_CMD_A           = 8'h16;
	localparam logic [7:0] READ_BANK_CMD_B           = 8'hc8;
	localparam logic [7:0] WRITE_BANK_VOLATILE_CMD_A = 8'h17;
	localparam logic [7:0] WRITE_BANK_VOLATILE_CMD_B = 8'hc5;
	localparam logic [7:0] WRITE_BANK_NONVOLATILE_CMD = 8'h18;
	localparam logic [7:0] ENTER_WIDE_ADDR_CMD       = 8'hb7;
	localparam logic [7:0] EXIT_WIDE_ADDR_CMD        = 8'h29;
	localparam logic [7:0] READ_PROTECTION_MODE_CMD  = 8'h2b;
	localparam logic [7:0] PROGRAM_PROTECTION_MODE_CMD = 8'h2f;
	localparam logic [7:0] CLEAR_EXTENDED_READ_CMD   = 8'h82;
	localparam logic [7:0] READ_BOOT_CMD             = 8'h14;
	localparam logic [7:0] WRITE_BOOT_CMD            = 8'h15;

	// ----------------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------------
	localparam int         FRAME_CNT_W = 7;
	localparam logic [6:0] OPCODE_BITS = 7'h08;
	localparam logic [6:0] BANK_BITS   = 7'h08;
	localparam logic [6:0] MODE_BITS   = 7'h10;
	localparam logic [6:0] BOOT_BITS   = 7'h20;
	localparam logic [6:0] NO_BITS     = 7'h00;

	// ----------------------------------------------------------------------
	// register fields and reset values
	// ----------------------------------------------------------------------
	localparam int          BANK_UPPER_SEG_POS = 0;
	localparam int          BANK_FOUR_BYTE_POS = 7;
	localparam logic [7:0]  BANK_RESET         = 8'h00;
	localparam logic [7:0]  BANK_WRITABLE      = 8'h81;
	localparam int          BOOT_ENABLE_POS    = 0;
	localparam int          BOOT_DELAY_LSB     = 1;
	localparam int          BOOT_DELAY_MSB     = 4;
	localparam int          BOOT_ADDR_LSB      = 5;
	localparam logic [31:0] BOOT_RESET         = 32'h0000_0000;
	localparam int          MODE_PARAM_LOC_POS = 15;
	localparam int          MODE_PWD_LOCK_POS  = 2;
	localparam int          MODE_PST_LOCK_POS  = 1;
	localparam logic [15:0] MODE_RESET         = 16'hffff;
	localparam logic [1:0]  LOCK_NONE          = 2'b11;
	localparam logic [1:0]  LOCK_ILLEGAL       = 2'b00;
	localparam logic [3:0]  DELAY_DEFAULT_SERIAL = 4'h8;
	localparam logic [3:0]  DELAY_DEFAULT_QUAD   = 4'h6;
	localparam int          ERR_PROT = 0;
	localparam int          ERR_PROG = 1;
	localparam int          ERR_ERASE = 2;

	// bits returned by a read command, zero for anything else
	function automatic logic [6:0] fcr_rd_bits(input logic [7:0] op);
		if (op == READ_BANK_CMD_A || op == READ_BANK_CMD_B)
			return BANK_BITS;
		else if (op == READ_PROTECTION_MODE_CMD)
			return MODE_BITS;
		else if (op == READ_BOOT_CMD)
			return BOOT_BITS;
		else
			return NO_BITS;
	endfunction : fcr_rd_bits

endpackage : fcr_pkg

// ==== fcr_sync3.sv ====
/*
 * Three-flop level synchroniser with agreement filter.
 * Assumes din is asynchronous to clk; dout moves only when stages two and three agree.
 */
`timescale 1ns/1ps
module fcr_sync3 #(
	parameter logic INIT = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic din,
	output logic      dout
);

	logic s1;
	logic s2;
	logic s3;

	// ----------------------------------------------------------------------
	// chain and filter
	// ----------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1   <= INIT;
			s2   <= INIT;
			s3   <= INIT;
			dout <= INIT;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				dout <= s3;
		end
	end

endmodule : fcr_sync3
